// >>> qsm_bit_src.sv
// Serial bit source that feeds symbol groups into the mapper
`timescale 1ns/10ps
module qsm_bit_src
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Load request
  input  wire logic        start_i,
  input  wire logic [11:0] word_i,
  input  wire logic [3:0]  len_i,
  output logic             busy_o,
  // Bit handshake
  input  wire logic        ready_i,
  output logic             bit_o,
  output logic             valid_o
);
  logic [11:0] word_r;
  logic [3:0]  cnt_r;
  logic        last_r;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_r <= 12'h000;
      cnt_r  <= 4'h0;
      last_r <= 1'b0;
    end
    else if (start_i)
    begin
      word_r <= word_i;
      cnt_r  <= len_i;
    end
    else if (valid_o && ready_i)
    begin
      cnt_r  <= cnt_r - 4'h1;
      last_r <= bit_o;
    end
  end
  // One group of len_i bits, held until taken
  assign valid_o = (cnt_r != 4'h0);
  // Idle line shows the inverse of the last bit, so a stale value never matches
  assign bit_o   = valid_o ? word_r[cnt_r - 4'h1] : ~last_r;
  assign busy_o  = valid_o;
endmodule : qsm_bit_src

// >>> qsm_mapper.sv
// Transmit clock source selection, QAM symbol mapper and modulator
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module qsm_mapper
  import qsm_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [3:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Clock source status
  input  wire logic                     net_clk_ok_i,
  input  wire logic                     rx_clk_ok_i,
  input  wire logic                     link_up_i,
  output logic      [1:0]               tx_clk_sel_o,
  output logic                          activate_o,
  // Serial bit input
  input  wire logic                     bit_i,
  input  wire logic                     bit_valid_i,
  output logic                          bit_ready_o,
  // Symbol and line sample outputs
  output logic signed [LVL_W-1:0]       sym_i_o,
  output logic signed [LVL_W-1:0]       sym_q_o,
  output logic                          sym_valid_o,
  output logic signed [19:0]            tx_sample_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]             ctrl_r;
  logic [31:0]             rate_r;
  logic                    under_r;
  logic                    ack_r;
  logic [31:0]             rdat_r;
  logic                    wr_stb;
  logic [3:0]              m_val;
  logic [15:0]             sym_mult;
  logic [15:0]             car_mult;

  assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign m_val    = ctrl_r[CTRL_M_LSB +: 4];
  assign sym_mult = rate_r[15:0];
  assign car_mult = rate_r[31:16];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = nw[8*b +: 8];
    merge = res;
  endfunction : merge

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= CTRL_RST;
      rate_r <= RATE_RST;
    end
    else if (wr_stb && wb_adr_i == REG_CTRL)
      ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
    else if (wr_stb && wb_adr_i == REG_RATE)
      rate_r <= merge(rate_r, wb_dat_i, wb_sel_i);
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end

  logic [1:0] quad_r;
  logic [1:0] src_r;
  logic       act_r;
  logic signed [LVL_W-1:0] si_r;
  logic signed [LVL_W-1:0] sq_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_r <= 32'h0;
    else
      case (wb_adr_i)
        REG_CTRL:   rdat_r <= ctrl_r;
        REG_RATE:   rdat_r <= rate_r;
        REG_STATUS: rdat_r <= {26'h0, act_r, under_r, quad_r, src_r};
        REG_SYMBOL: rdat_r <= {16'h0, sq_r, si_r};
        default:    rdat_r <= 32'h0;
      endcase
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit clock source
  qsm_src_t src_nxt;

  always_comb
  begin
    if (!ctrl_r[CTRL_REMOTE_BIT])
      src_nxt = net_clk_ok_i ? SRC_NET : SRC_LOCAL;
    else if (rx_clk_ok_i)
      src_nxt = ctrl_r[CTRL_RXSEL_BIT] ? SRC_RX2 : SRC_RX1;
    else
      src_nxt = SRC_LOCAL;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_r <= 2'(SRC_LOCAL);
      act_r <= 1'b0;
    end
    else
    begin
      src_r <= 2'(src_nxt);
      // Link activation only when the loop clock drops in steady state
      act_r <= ctrl_r[CTRL_REMOTE_BIT] && !rx_clk_ok_i && (link_up_i || act_r);
    end
  end

  assign tx_clk_sel_o = src_r;
  assign activate_o   = act_r;

  ////////////////////////////////////////////////////////////////////////////
  // One phase reference for symbol and carrier timing
  logic [31:0] sym_acc_r;
  logic [31:0] car_acc_r;
  logic [32:0] sym_sum;
  logic        sym_tick;

  // Both increments scale the same half-base step, so their ratio stays exact
  assign sym_sum  = {1'b0, sym_acc_r} + {1'b0, 32'(sym_mult * HALF_BASE_INC * 2)};
  assign sym_tick = sym_sum[32] && ctrl_r[CTRL_EN_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_r[CTRL_EN_BIT])
    begin
      sym_acc_r <= 32'h0;
      car_acc_r <= 32'h0;
    end
    else
    begin
      sym_acc_r <= sym_sum[31:0];
      car_acc_r <= car_acc_r + 32'(car_mult * HALF_BASE_INC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit collection
  logic [MAX_M-1:0] grp_r;
  logic [3:0]       cnt_r;
  logic [3:0]       cnt_nxt;
  logic             rdy_r;
  logic             take;

  assign take = bit_valid_i && rdy_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (sym_tick && cnt_r == m_val)
      cnt_nxt = 4'h0;
    else if (take)
      cnt_nxt = cnt_r + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grp_r <= '0;
      cnt_r <= 4'h0;
      rdy_r <= 1'b0;
    end
    else
    begin
      if (take)
        grp_r <= {grp_r[MAX_M-2:0], bit_i};
      cnt_r <= cnt_nxt;
      rdy_r <= cnt_nxt < m_val;
    end
  end

  assign bit_ready_o = rdy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Constellation mapping
  function automatic logic gbit(input logic [MAX_M-1:0] g, input int m, input int n);
    gbit = g[m - n];
  endfunction : gbit

  // Cumulative XOR run of len bits from bit first, then a trailing one
  function automatic logic [7:0] cum(input logic [MAX_M-1:0] g, input int m, input int first,
                                     input int len);
    logic [7:0] v;
    logic       a;
    v = 8'h0;
    a = 1'b0;
    for (int i = 0; i < 6; i++)
      if (i < len)
      begin
        a = a ^ gbit(g, m, first + i);
        v = {v[6:0], a};
      end
    cum = {v[6:0], 1'b1};
  endfunction : cum

  function automatic logic [15:0] map_q1(input logic [MAX_M-1:0] g, input int m);
    logic [5:0] sec;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] span;
    int         n;
    x   = 8'h1;
    y   = 8'h1;
    sec = 6'h0;
    n   = (m - 5) / 2;
    if (m == 3)
    begin
      x = gbit(g, m, 3) ? 8'h3 : 8'h1;
      y = gbit(g, m, 3) ? 8'h3 : 8'h1;
    end
    else if (m >= 4 && m[0] == 1'b0)
    begin
      x = cum(g, m, 3, m / 2 - 1);
      y = cum(g, m, m / 2 + 2, m / 2 - 1);
    end
    else if (m >= 5)
    begin
      sec  = qsm_section({gbit(g, m, 3), gbit(g, m, 4), gbit(g, m, 5)});
      span = 8'(2 << n);
      x    = cum(g, m, 6, n);
      y    = cum(g, m, 6 + n, n);
      if (sec[1])
        x = span - x;
      if (sec[0])
        y = span - y;
      x = x + 8'(sec[5:4] * span);
      y = y + 8'(sec[3:2] * span);
    end
    map_q1 = {x, y};
  endfunction : map_q1

  logic [1:0]  quad_nxt;
  logic [15:0] q1;
  logic signed [LVL_W-1:0] xi;
  logic signed [LVL_W-1:0] yq;
  logic signed [LVL_W-1:0] i_nxt;
  logic signed [LVL_W-1:0] q_nxt;
  logic [1:0]  b12;

  assign b12 = {gbit(grp_r, 32'(m_val), 1), gbit(grp_r, 32'(m_val), 2)};
  assign q1  = map_q1(grp_r, 32'(m_val));
  assign xi  = $signed(q1[15:8]);
  assign yq  = $signed(q1[7:0]);

  always_comb
  begin
    if (m_val == 4'h1)
      quad_nxt = gbit(grp_r, 1, 1) ? quad_r + 2'h2 : quad_r;
    else
      case (b12)
        2'b10:   quad_nxt = quad_r + 2'h1;
        2'b01:   quad_nxt = quad_r - 2'h1;
        2'b11:   quad_nxt = quad_r + 2'h2;
        default: quad_nxt = quad_r;
      endcase
    case (quad_nxt)
      2'h1:    begin i_nxt = -yq; q_nxt = xi;  end
      2'h2:    begin i_nxt = -xi; q_nxt = -yq; end
      2'h3:    begin i_nxt = yq;  q_nxt = -xi; end
      default: begin i_nxt = xi;  q_nxt = yq;  end
    endcase
  end

  logic sym_ok;
  logic vld_r;
  assign sym_ok = sym_tick && cnt_r == m_val && m_val != 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      quad_r  <= QUAD_FIRST;
      si_r    <= '0;
      sq_r    <= '0;
      vld_r   <= 1'b0;
      under_r <= 1'b0;
    end
    else
    begin
      vld_r <= sym_ok;
      if (sym_ok)
      begin
        quad_r <= quad_nxt;
        si_r   <= i_nxt;
        sq_r   <= q_nxt;
      end
      else if (sym_tick)
      begin
        // Starved symbol slot zeroes the symbol outputs but not the filter history, and keeps the quadrant reference
        si_r <= '0;
        sq_r <= '0;
      end
      // Set wins over a write-one clear in the same cycle
      if (sym_tick && !sym_ok)
        under_r <= 1'b1;
      else if (wr_stb && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STAT_UNDER_BIT])
        under_r <= 1'b0;
    end
  end

  assign sym_i_o     = si_r;
  assign sym_q_o     = sq_r;
  assign sym_valid_o = vld_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shaping filters and mixer
  logic signed [LVL_W-1:0] hist_r [2][3];
  logic signed [10:0]      filt   [2];
  logic signed [19:0]      mix    [2];
  logic signed [19:0]      out_r;
  logic [3:0]              ph;

  assign ph = car_acc_r[31:28];

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_path
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          hist_r[p] <= '{default: '0};
        else if (vld_r)
          hist_r[p] <= '{(p == 0) ? si_r : sq_r, hist_r[p][0], hist_r[p][1]};
      end
      assign filt[p] = 11'(hist_r[p][0]) + (11'(hist_r[p][1]) <<< 1) + 11'(hist_r[p][2]);
    end
  endgenerate

  // Widen before multiplying so the product keeps its top bits
  assign mix[0] = 20'(filt[0]) * 20'(qsm_sine(ph + 4'h4));
  assign mix[1] = 20'(filt[1]) * 20'(qsm_sine(ph));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_r <= '0;
    else
      out_r <= mix[0] - mix[1];
  end

  assign tx_sample_o = out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  office_src_a: assert property (!ctrl_r[CTRL_REMOTE_BIT] && net_clk_ok_i
    |=> tx_clk_sel_o == 2'(SRC_NET)) else $error("office not on network clock");
  loop_src_a: assert property (ctrl_r[CTRL_REMOTE_BIT] && rx_clk_ok_i && !ctrl_r[CTRL_RXSEL_BIT]
    |=> tx_clk_sel_o == 2'(SRC_RX1)) else $error("remote not loop timed");
  lost_clk_a: assert property (ctrl_r[CTRL_REMOTE_BIT] && link_up_i && !rx_clk_ok_i
    |=> tx_clk_sel_o == 2'(SRC_LOCAL) && activate_o) else $error("no local fallback");
  group_len_a: assert property (sym_ok |=> cnt_r == 4'h0 && bit_ready_o)
    else $error("group count not restarted");
  sym_out_a: assert property (sym_ok |=> sym_valid_o && sym_i_o[0] && sym_q_o[0])
    else $error("symbol not odd level");
  bpsk_quad_a: assert property (sym_ok && m_val == 4'h1
    |=> quad_r[0] == 1'b0) else $error("one-bit symbol left axis");
  opp_quad_a: assert property (sym_ok && m_val != 4'h1 && b12 == 2'b11
    |=> quad_r == $past(quad_r) + 2'h2) else $error("opposite move wrong");
  keep_quad_a: assert property (!sym_ok |=> $stable(quad_r)) else $error("quadrant drift");
  mix_cos_a: assert property (ph == 4'h0 |=> tx_sample_o == 20'($past(filt[0]) * 20'sd127))
    else $error("in-phase product wrong");
  mix_sin_a: assert property (ph == 4'h4 |=> tx_sample_o == 20'(-($past(filt[1]) * 20'sd127)))
    else $error("quadrature product not inverted");
  ready_a: assert property (cnt_r == m_val && !sym_tick |=> !bit_ready_o)
    else $error("ready with full group");

endmodule : qsm_mapper

// >>> qsm_pkg.sv
// Constants, register map and shared decoders for the QAM symbol mapper
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Office side: network clock, else local 50 ppm
// - Remote side: loop timing from chosen downstream carrier
// - Remote loses receive clock: local clock, activate
// - Emit one I and Q pair per symbol
// - Input is serial bits, MSB first
// - M consecutive bits form one symbol
// - Quadrant is differential against previous symbol
// - M=1: one toggles first and third quadrants
// - 00 keep, 10 ccw, 01 cw, 11 opposite
// - Square: cumulative XOR magnitudes, trailing one
// - Cross: eight sections chosen by b3 b4 b5
// - Cross: cumulative inner position, then section mirroring
// - Other quadrants rotate first quadrant counter-clockwise
// - Component levels are exact odd integers
// - Identical shaping filters, cosine and sine mixing
// - Output is I product minus Q product
// - Symbol rate is integer multiple of base
// - Carrier is integer multiple of half base
// - Symbol and carrier share one phase reference
////////////////////////////////////////////////////////////////////////////////
package qsm_pkg;

  // Wishbone register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_RATE   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_SYMBOL = 4'hc;

  // Field positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_REMOTE_BIT = 1;
  localparam int CTRL_RXSEL_BIT  = 2;
  localparam int CTRL_M_LSB      = 4;
  localparam int STAT_UNDER_BIT  = 4;
  localparam int STAT_ACT_BIT    = 5;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [31:0] RATE_RST = 32'h0040_0040;

  // Timing reference
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint HALF_BASE_HZ  = 16_875;
  localparam int     LOCAL_PPM_MAX = 50;
  localparam logic [31:0] HALF_BASE_INC =
    32'(((64'd1 << 32) * HALF_BASE_HZ) / CLK_HZ);

  localparam int MAX_M   = 12;
  localparam int LVL_W   = 8;
  localparam logic [1:0] QUAD_FIRST = 2'h0;

  typedef enum {SRC_NET, SRC_LOCAL, SRC_RX1, SRC_RX2} qsm_src_t;

  // Sixteen-phase sine, amplitude 127
  function automatic logic signed [7:0] qsm_sine(input logic [3:0] ph);
    case (ph)
      4'h0, 4'h8: qsm_sine = 8'sh00;
      4'h1, 4'h7: qsm_sine = 8'sh31;
      4'h2, 4'h6: qsm_sine = 8'sh5a;
      4'h3, 4'h5: qsm_sine = 8'sh75;
      4'h4:       qsm_sine = 8'sh7f;
      4'h9, 4'hf: qsm_sine = -8'sh31;
      4'ha, 4'he: qsm_sine = -8'sh5a;
      4'hb, 4'hd: qsm_sine = -8'sh75;
      default:    qsm_sine = -8'sh7f;
    endcase
  endfunction : qsm_sine

  // Cross section: {col[1:0], row[1:0], mirror_h, mirror_v}
  function automatic logic [5:0] qsm_section(input logic [2:0] code);
    case (code)
      3'h0:    qsm_section = 6'b00_00_0_0;
      3'h1:    qsm_section = 6'b01_00_1_0;
      3'h2:    qsm_section = 6'b00_01_0_1;
      3'h3:    qsm_section = 6'b01_01_1_1;
      3'h4:    qsm_section = 6'b10_00_0_0;
      3'h5:    qsm_section = 6'b00_10_0_0;
      3'h6:    qsm_section = 6'b10_01_0_1;
      default: qsm_section = 6'b01_10_1_0;
    endcase
  endfunction : qsm_section

endpackage : qsm_pkg

// >>> test_qsm_mapper.sv
// Self-checking testbench for the QAM symbol mapper
`timescale 1ns/10ps
module test_qsm_mapper;
  import qsm_pkg::*;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
  logic                    net = 1'b0, rxok = 1'b0, lnk = 1'b0;
  logic [3:0]              adr = 4'h0, sel = 4'h0, len = 4'h0;
  logic [31:0]             wdat = 32'h0, rdat, rd, ei, eq;
  logic [11:0]             word = 12'h000;
  logic [7:0]              c;
  logic [1:0]              csel;
  logic                    bw, bv, brdy, ack, act, sv, busy;
  logic signed [LVL_W-1:0] si, sq;
  logic signed [19:0]      smp;
  int num_errors = 0, num_checks = 0, ncyc = 0, tprev, per, q, n, i;
  bit first;
  int mt[17] = '{2, 2, 2, 2, 2, 2, 4, 4, 4, 4, 1, 1, 1, 6, 6, 8, 12};
  logic [11:0] gt[17] = '{12'h002, 12'h001, 12'h003, 12'h000, 12'h003, 12'h001, 12'h003,
    12'h00a, 12'h00d, 12'h006, 12'h001, 12'h000, 12'h001, 12'h001, 12'h02b, 12'h069, 12'hf0f};
  // {remote, carrier2, net ok, rx ok, link up, source, activate}
  logic [7:0] cs[5] = '{8'h20, 8'h02, 8'h9c, 8'hde, 8'hcb};
  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) ncyc <= ncyc + 1;
  qsm_mapper i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .net_clk_ok_i(net), .rx_clk_ok_i(rxok), .link_up_i(lnk),
    .tx_clk_sel_o(csel), .activate_o(act), .bit_i(bw), .bit_valid_i(bv),
    .bit_ready_o(brdy), .sym_i_o(si), .sym_q_o(sq), .sym_valid_o(sv), .tx_sample_o(smp));
  qsm_bit_src i_src (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .word_i(word),
    .len_i(len), .busy_o(busy), .ready_i(brdy), .bit_o(bw), .valid_o(bv));
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
    if (k >= 50) num_errors++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task reset_dut;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("tx_sample_o", 32'h0, 32'(smp));
  endtask : reset_dut
  task send(input logic [11:0] g, input int m);
    int k;
    k = 0;
    @(posedge clk_i);
    start <= 1'b1;
    word  <= g;
    len   <= 4'(m);
    @(posedge clk_i);
    start <= 1'b0;
    do @(posedge clk_i); while (busy === 1'b1 && ++k < 100);
  endtask : send
  // Reference mapping: differential quadrant, cumulative magnitudes, rotation
  task model(input int m, input logic [11:0] g, inout int qd);
    int k, x, y, h;
    logic a;
    if (m == 1)
      qd = g[0] ? (qd + 2) % 4 : qd;
    else
      case ({g[m-1], g[m-2]})
        2'b10: qd = (qd + 1) % 4;
        2'b01: qd = (qd + 3) % 4;
        2'b11: qd = (qd + 2) % 4;
        default: ;
      endcase
    h = m / 2;
    x = 0;
    y = 0;
    a = 1'b0;
    for (k = 3; k <= h + 1; k++)
    begin
      a = a ^ g[m-k];
      x = 2 * x + a;
    end
    a = 1'b0;
    for (k = h + 2; k <= m; k++)
    begin
      a = a ^ g[m-k];
      y = 2 * y + a;
    end
    x = 2 * x + 1;
    y = 2 * y + 1;
    case (qd)
      0: begin ei = x;  eq = y;  end
      1: begin ei = -y; eq = x;  end
      2: begin ei = -x; eq = -y; end
      default: begin ei = y; eq = -x; end
    endcase
  endtask : model
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    per = int'((64'd1 << 32) / (64'(RATE_RST[15:0]) * 2 * 64'(HALF_BASE_INC)));
    reset_dut();
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl", CTRL_RST, rd);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0, rd);
    for (i = 0; i < 5; i++)
    begin
      c = cs[i];
      net  <= c[5];
      rxok <= c[4];
      lnk  <= c[3];
      wb(1'b1, REG_CTRL, {24'h0, 4'h4, 1'b0, c[6], c[7], 1'b1});
      n = 0;
      while ((csel !== c[2:1] || act !== c[0]) && n < 20)
      begin
        @(posedge clk_i);
        n++;
      end
      check("tx_clk_sel_o", 32'(c[2:1]), 32'(csel));
      check("activate_o", 32'(c[0]), 32'(act));
    end
    wb(1'b0, REG_RATE, 32'h0);
    check("rate", RATE_RST, rd);
    // Enabled with no bits: at least one starved tick must have passed
    repeat (50) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status", 32'h31, rd);
    wb(1'b1, REG_CTRL, 32'h40);
    wb(1'b1, REG_STATUS, 32'h10);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status clear", 32'h01, rd);
    for (i = 0; i < 17; i++)
    begin
      if (i == 0 || mt[i] != mt[i-1])
      begin
        // Fresh reset per size so each run starts from the first quadrant
        reset_dut();
        q = 0;
        first = 1'b1;
        wb(1'b1, REG_CTRL, {24'h0, 4'(mt[i]), 4'h0});
      end
      send(gt[i], mt[i]);
      if (first) wb(1'b1, REG_CTRL, {24'h0, 4'(mt[i]), 4'h1});
      n = 0;
      do @(posedge clk_i); while (sv !== 1'b1 && ++n < 300);
      if (!first) check("symbol spacing", 32'h1, 32'(ncyc - tprev == per || ncyc - tprev == per + 1));
      tprev = ncyc;
      first = 1'b0;
      model(mt[i], gt[i], q);
      check("sym_i_o", ei, 32'(si));
      check("sym_q_o", eq, 32'(sq));
      wb(1'b0, REG_SYMBOL, 32'h0);
      check("symbol reg", {16'h0, eq[7:0], ei[7:0]}, rd);
      wb(1'b0, REG_STATUS, 32'h0);
      check("quadrant", 32'(q), 32'(rd[3:2]));
    end
    conclude();
  end
  // Whole run needs about a thousand cycles; this margin only catches a hang
  initial
  begin : watchdog
    #200000;
    num_errors++;
    conclude();
  end
endmodule : test_qsm_mapper
